// [tsp_timer8.sv]
// Local design decision: the APB interface to the registers.
`default_nettype none

module tsp_timer8 #(
  parameter int unsigned PRE_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tsp_pkg::tsp_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count pin and power state
  input wire logic external_count_pin,
  input wire logic sleep_mode,
  // watchdog side
  input wire logic watchdog_base_tick,
  input wire logic watchdog_clear_instruction,
  output logic watchdog_post_tick,
  // interrupt and port control
  output logic wrap_irq,
  output logic [7:0] port_a_direction
);

  import tsp_pkg::*;

  // the ratio tap cannot reach above bit seven
  generate
    if (PRE_W < 8 || PRE_W > 32) begin : g_width_check
      $error("tsp_timer8 divider width must be 8 to 32");
    end
  endgenerate

  // registers
  logic [7:0] timer_count_r;
  logic [7:0] irq_control_r;
  tsp_option_t option_r;
  logic [7:0] port_a_direction_r;

  // bus answer flops
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // counting path
  logic [1:0] phase_r;
  logic [3:0] hold_r;
  logic src_d_r;
  logic samp_r;
  logic samp_d_r;
  logic pre_out_d_r;
  logic wrap_irq_r;
  logic watchdog_post_tick_r;

  // combinational helpers
  logic setup;
  logic wr_en;
  logic sel_timer;
  logic sel_irq;
  logic sel_option;
  logic sel_porta;
  logic mapped;
  logic tc_wr;
  logic irq_wr;
  logic opt_wr;
  logic pa_wr;
  logic [7:0] rd_byte;
  logic src_lvl;
  logic src_rise;
  logic pre_step;
  logic pre_clear;
  logic [2:0] pre_tap;
  logic pre_out;
  logic [PRE_W-1:0] pre_cnt;
  logic div_lvl;
  logic inc_pulse;
  logic count_en;
  logic wrap;
  logic pre_rise;

  // address decode, exact word addresses only
  assign sel_timer = (paddr == ADDR_TIMER);
  assign sel_irq = (paddr == ADDR_IRQ);
  assign sel_option = (paddr == ADDR_OPTION);
  assign sel_porta = (paddr == ADDR_PORTA);
  assign mapped = sel_timer | sel_irq | sel_option | sel_porta;

  // writes land at the completing access edge, low lane only
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready_r & pstrb[0];
  assign tc_wr = wr_en & sel_timer;
  assign irq_wr = wr_en & sel_irq;
  assign opt_wr = wr_en & sel_option;
  assign pa_wr = wr_en & sel_porta;

  // divider kept off the bus
  // read mux; the divider count has no path here on purpose
  always_comb begin
    rd_byte = 8'h00;
    if (sel_timer) begin
      rd_byte = timer_count_r;
    end else if (sel_irq) begin
      rd_byte = irq_control_r;
    end else if (sel_option) begin
      rd_byte = option_r;
    end else if (sel_porta) begin
      rd_byte = port_a_direction_r;
    end
  end

  // apb answer: data latched in setup, zero wait states
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= {24'h00_0000, rd_byte};
      pslverr_r <= ~mapped;
    end else if (psel & penable) begin
      pslverr_r <= 1'b0;
    end
  end

  // ready stays high; every access completes in one access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r <= 1'b1;
    end else begin
      pready_r <= 1'b1;
    end
  end

  // four phases per cycle
  // free running phase counter, q1 to q4
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // assignment bit stored
  // option register; assignment and ratio change only by software
  always_ff @(posedge clk) begin
    if (reset) begin
      option_r <= RST_OPTION;
    end else if (opt_wr) begin
      option_r <= pwdata[7:0];
    end
  end

  // port direction is kept here and handed to the port logic
  always_ff @(posedge clk) begin
    if (reset) begin
      port_a_direction_r <= RST_PORTA;
    end else if (pa_wr) begin
      port_a_direction_r <= pwdata[7:0] & PORTA_MASK;
    end
  end

  // edge polarity select
  // inverting the pin makes a falling edge look like a rising one
  always_comb begin
    if (option_r.count_source_select) begin
      src_lvl = external_count_pin ^ option_r.count_edge_select;
    end else begin
      src_lvl = phase_r[1];
    end
  end

  // edge of the chosen source feeds the divider while the timer owns it
  always_ff @(posedge clk) begin
    if (reset) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src_lvl;
    end
  end
  assign src_rise = src_lvl & ~src_d_r;

  // single shared divider
  // the divider steps on timer edges or on watchdog ticks, never both
  assign pre_step = option_r.divider_assign ? watchdog_base_tick : src_rise;

  assign pre_clear = (tc_wr & ~option_r.divider_assign)
                   | (watchdog_clear_instruction & option_r.divider_assign);

  // tap n gives two to n plus one
  // watchdog side taps one bit lower so its field runs from 1:1
  assign pre_tap = option_r.divider_assign ? (option_r.divider_ratio_field - 3'h1)
                                           : option_r.divider_ratio_field;

  tsp_prescaler #(
    .PRE_W(PRE_W)
  ) u_prescaler (
    .clk(clk),
    .reset(reset),
    .step(pre_step),
    .clear(pre_clear),
    .tap(pre_tap),
    .tap_out(pre_out),
    .count(pre_cnt)
  );

  assign div_lvl = option_r.divider_assign ? src_lvl : pre_out;

  // sample at phase two and four
  // sampler off in sleep
  // two samples per cycle, so a level must last half a cycle to be seen
  always_ff @(posedge clk) begin
    if (reset) begin
      samp_r <= 1'b1; // idle high so a high source after reset is no rise
    end else if (!sleep_mode && (phase_r == PH_Q2 || phase_r == PH_Q4)) begin
      samp_r <= div_lvl;
    end
  end

  // delayed increment after edge
  // increment comes one clock after the sample that saw the rise
  always_ff @(posedge clk) begin
    if (reset) begin
      samp_d_r <= 1'b1; // matches the sample flop, no false edge
    end else begin
      samp_d_r <= samp_r;
    end
  end
  assign inc_pulse = samp_r & ~samp_d_r;

  // two cycle write hold
  // counted in clocks so the hold is a full two cycles from any phase
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_r <= 4'h0;
    end else if (tc_wr) begin
      hold_r <= 4'(WRITE_HOLD_CLK);
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end

  assign count_en = inc_pulse & (hold_r == 4'h0) & ~sleep_mode;
  assign wrap = count_en & ~tc_wr & (timer_count_r == 8'hff);

  // count register; a software write beats a same cycle increment
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_count_r <= RST_TIMER;
    end else if (tc_wr) begin
      timer_count_r <= pwdata[7:0];
    end else if (count_en) begin
      timer_count_r <= timer_count_r + 8'h01;
    end
  end

  // wrap sets flag
  // a wrap in the cycle of a clearing write still leaves the flag set
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_control_r <= RST_IRQ;
    end else if (irq_wr) begin
      irq_control_r <= pwdata[7:0];
      irq_control_r[BIT_WRAP_FLAG] <= pwdata[BIT_WRAP_FLAG] | wrap;
    end else if (wrap) begin
      irq_control_r[BIT_WRAP_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrap_irq_r <= 1'b0;
    end else begin
      wrap_irq_r <= irq_control_r[BIT_WRAP_FLAG] & irq_control_r[BIT_WRAP_EN];
    end
  end

  // rise of the watchdog tap marks one divided tick
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_out_d_r <= 1'b0;
    end else begin
      pre_out_d_r <= pre_out;
    end
  end
  assign pre_rise = pre_out & ~pre_out_d_r;

  // watchdog divided or not
  // ratio zero on the watchdog side passes ticks straight through
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_post_tick_r <= 1'b0;
    end else if (option_r.divider_assign &&
                 option_r.divider_ratio_field != 3'h0) begin
      watchdog_post_tick_r <= pre_rise;
    end else begin
      watchdog_post_tick_r <= watchdog_base_tick;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wrap_irq = wrap_irq_r;
  assign watchdog_post_tick = watchdog_post_tick_r;
  assign port_a_direction = port_a_direction_r;

  internal_rate_a: assert property (
    @(posedge clk) disable iff (reset)
    (count_en && !option_r.count_source_select && option_r.divider_assign &&
     !sleep_mode && !tc_wr && !opt_wr)
    ##1 (!sleep_mode && !tc_wr && !opt_wr)[*3] ##1 !sleep_mode |-> count_en)
    else $error("internal count missed a cycle");

  write_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    tc_wr |=> (!count_en)[*8])
    else $error("count moved within two cycles of a write");

  wrap_flag_a: assert property (
    @(posedge clk) disable iff (reset)
    (count_en && !tc_wr && timer_count_r == 8'hff) |=>
    (timer_count_r == 8'h00) && irq_control_r[BIT_WRAP_FLAG])
    else $error("wrap did not set flag");

  flag_set_wins_a: assert property (
    @(posedge clk) disable iff (reset)
    (irq_wr && wrap) |=> irq_control_r[BIT_WRAP_FLAG])
    else $error("wrap lost against clearing write");

  irq_mask_a: assert property (
    @(posedge clk) disable iff (reset)
    (!irq_control_r[BIT_WRAP_EN] ##1 !irq_control_r[BIT_WRAP_EN]) |-> !wrap_irq)
    else $error("masked request reached output");

  sleep_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    (sleep_mode && !tc_wr) |=> $stable(timer_count_r))
    else $error("count moved during sleep");

  sample_phase_a: assert property (
    @(posedge clk) disable iff (reset)
    inc_pulse |-> (phase_r == PH_Q3 || phase_r == PH_Q1))
    else $error("increment outside sample phases");

  pre_clear_tc_a: assert property (
    @(posedge clk) disable iff (reset)
    (tc_wr && !option_r.divider_assign) |=> (pre_cnt == '0))
    else $error("count write left divider running");

  pre_clear_wd_a: assert property (
    @(posedge clk) disable iff (reset)
    (watchdog_clear_instruction && option_r.divider_assign) |=> (pre_cnt == '0))
    else $error("watchdog clear left divider running");

  // watchdog undivided when timer owns divider
  watchdog_pass_a: assert property (
    @(posedge clk) disable iff (reset)
    !option_r.divider_assign |=> (watchdog_post_tick == $past(watchdog_base_tick)))
    else $error("watchdog tick divided without divider");

endmodule : tsp_timer8

`default_nettype wire

// [tsp_pkg.sv]
`default_nettype none

package tsp_pkg;

  // bus geometry
  localparam int unsigned TSP_ADDR_W = 12;
  typedef logic [TSP_ADDR_W-1:0] tsp_addr_t;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER = 8'h01;
  localparam logic [7:0] IDX_IRQ = 8'h0b;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PORTA = 8'h85;
  localparam tsp_addr_t ADDR_TIMER = tsp_addr_t'({IDX_TIMER, 2'b00});
  localparam tsp_addr_t ADDR_IRQ = tsp_addr_t'({IDX_IRQ, 2'b00});
  localparam tsp_addr_t ADDR_OPTION = tsp_addr_t'({IDX_OPTION, 2'b00});
  localparam tsp_addr_t ADDR_PORTA = tsp_addr_t'({IDX_PORTA, 2'b00});

  // reset values
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_PORTA = 8'h3f;
  localparam logic [7:0] PORTA_MASK = 8'h3f;

  // irq control field positions
  localparam int unsigned BIT_WRAP_EN = 5;
  localparam int unsigned BIT_WRAP_FLAG = 2;

  // timing: oscillator clocks per instruction cycle
  localparam int unsigned CLK_PER_CYC = 4;
  localparam int unsigned WRITE_HOLD_CYC = 2;
  localparam int unsigned WRITE_HOLD_CLK = WRITE_HOLD_CYC * CLK_PER_CYC;

  // internal phase encoding, q1 first
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // option register layout, msb first
  typedef struct packed {
    logic pullup_off;
    logic irq_edge;
    logic count_source_select;
    logic count_edge_select;
    logic divider_assign;
    logic [2:0] divider_ratio_field;
  } tsp_option_t;

endpackage : tsp_pkg

`default_nettype wire

// [tsp_prescaler.sv]
`default_nettype none

module tsp_prescaler #(
  parameter int unsigned PRE_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic step,
  input wire logic clear,
  input wire logic [2:0] tap,
  // results
  output logic tap_out,
  output logic [PRE_W-1:0] count
);

  logic [PRE_W-1:0] cnt_r;
  logic tap_r;

  // the tap select reaches bit seven at most
  generate
    if (PRE_W < 8) begin : g_width_check
      $error("tsp_prescaler needs at least eight bits");
    end
  endgenerate

  // divider ahead of sampler
  // synchronous stand-in for a ripple chain; a tap bit is still a square wave
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (clear) begin
      cnt_r <= '0;
    end else if (step) begin
      cnt_r <= cnt_r + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // registered tap keeps the divided output glitch free
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      tap_r <= 1'b0;
    end else begin
      tap_r <= cnt_r[tap];
    end
  end

  assign tap_out = tap_r;
  assign count = cnt_r;

endmodule : tsp_prescaler

`default_nettype wire

// [tsp_pin_model.sv]
`default_nettype none

// far side: a source on the external count pin
module tsp_pin_model (
  // clock
  input wire logic clk,
  // count pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle low until the bench asks for a level
  initial pin = 1'b0;

  // two clock floor
  // shorter holds could slip between the two samples of a cycle
  task automatic set_level(input logic v, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    pin <= v;
    repeat (h) @(posedge clk);
  endtask : set_level

endmodule : tsp_pin_model

`default_nettype wire

// [tsp_timer8_tb.sv]
`default_nettype none

module tsp_timer8_tb;
  import tsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, reset, psel, penable, pwrite, sleep_mode, wd_tick, wd_clr;
  logic pready, pslverr, ext_pin, wd_post, wrap_irq, err;
  tsp_addr_t paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] port_dir;
  int err_total, comparisons, cycles, posts;
  tsp_addr_t ra [4] = '{ADDR_TIMER, ADDR_IRQ, ADDR_OPTION, ADDR_PORTA};
  logic [7:0] rv [4] = '{8'h00, 8'h00, 8'hff, 8'h3f};
  logic [7:0] wo [3] = '{8'h08, 8'h0b, 8'h00};
  int we [3] = '{16, 2, 16};

  tsp_timer8 DUT (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
    .sleep_mode(sleep_mode), .watchdog_base_tick(wd_tick),
    .watchdog_clear_instruction(wd_clr), .watchdog_post_tick(wd_post),
    .wrap_irq(wrap_irq), .port_a_direction(port_dir)
  );

  tsp_pin_model u_pin (.clk(clk), .pin(ext_pin));

  // 40 ns period
  always #20 clk = ~clk;

  // cycle count, post tick count and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wd_post === 1'b1) begin
      posts <= posts + 1;
    end
    if (cycles == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // window check where the phase of the first step is free
  task automatic chk_rng(input string what, input logic [7:0] lo, hi, got);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("mismatch %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // one apb transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input tsp_addr_t a, input logic [7:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends at the first edge with pready high; the cycle ceiling only guards a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input tsp_addr_t a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdv(input tsp_addr_t a);
    apb(1'b0, a, 8'h00, 4'hf);
  endtask : rdv

  // main sequence
  initial begin
    clk = 0;
    reset = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    sleep_mode = 0;
    wd_tick = 0;
    wd_clr = 0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    posts = 0;
    wait_clk(3);
    reset <= 0;
    wait_clk(1);
    // reset values, unmapped place, port a storage
    for (int i = 0; i < 4; i++) begin
      rdv(ra[i]);
      chk("reset value", {24'h0, rv[i]}, rd);
    end
    chk("ready", 32'h1, {31'h0, pready});
    rdv(12'h008);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr(ADDR_PORTA, 8'hc5);
    rdv(ADDR_PORTA);
    chk("port a", 32'h05, rd);
    chk("port a pins", 32'h05, {24'h0, port_dir});
    apb(1'b1, ADDR_PORTA, 8'h3f, 4'he);
    rdv(ADDR_PORTA);
    chk("port a strobe", 32'h05, rd);
    $display("test registers done");
    // internal clock, divider with the watchdog
    wr(ADDR_OPTION, 8'h08);
    wr(ADDR_TIMER, 8'h40);
    rdv(ADDR_TIMER);
    chk("timer held", 32'h40, rd);
    wait_clk(36);
    rdv(ADDR_TIMER);
    chk_rng("timer rate", 8'h47, 8'h49, rd[7:0]);
    sleep_mode <= 1'b1;
    wr(ADDR_TIMER, 8'h10);
    wait_clk(40);
    rdv(ADDR_TIMER);
    chk("sleep halt", 32'h10, rd);
    sleep_mode <= 1'b0;
    $display("test internal done");
    // wrap flag, mask, software clear
    wr(ADDR_IRQ, 8'h00);
    wr(ADDR_TIMER, 8'hfe);
    wait_clk(30);
    rdv(ADDR_IRQ);
    chk("wrap flag", 32'h04, rd);
    chk("masked irq", 32'h0, {31'h0, wrap_irq});
    wr(ADDR_IRQ, 8'h24);
    wait_clk(1);
    chk("enabled irq", 32'h1, {31'h0, wrap_irq});
    wr(ADDR_IRQ, 8'h20);
    wait_clk(1);
    chk("cleared irq", 32'h0, {31'h0, wrap_irq});
    wr(ADDR_IRQ, 8'h00);
    $display("test wrap done");
    // every ratio; a timer write clears the divider
    for (int n = 0; n < 8; n++) begin
      wr(ADDR_OPTION, 8'(n));
      wr(ADDR_TIMER, 8'h00);
      wait_clk((16 << n) + 6);
      rdv(ADDR_TIMER);
      // at 1:2 the write hold swallows the first divided step
      chk_rng("ratio", (n == 0) ? 8'h01 : 8'h02, 8'h02, rd[7:0]);
    end
    $display("test ratios done");
    // external pin, both edges, undivided
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_OPTION, (e == 1) ? 8'h38 : 8'h28);
      wait_clk(10);
      wr(ADDR_TIMER, 8'h00);
      wait_clk(10);
      u_pin.set_level(1'b1, 20);
      rdv(ADDR_TIMER);
      chk("after rise", (e == 1) ? 32'h0 : 32'h1, rd);
      u_pin.set_level(1'b0, 20);
      rdv(ADDR_TIMER);
      chk("after fall", 32'h1, rd);
    end
    // external pin through the divider at 1:2
    wr(ADDR_OPTION, 8'h20);
    wait_clk(10);
    wr(ADDR_TIMER, 8'h00);
    // let the write hold run out before the first pin edge
    wait_clk(8);
    repeat (8) begin
      u_pin.set_level(1'b1, 2);
      u_pin.set_level(1'b0, 2);
    end
    wait_clk(20);
    rdv(ADDR_TIMER);
    chk("divided pin", 32'h4, rd);
    $display("test external done");
    // watchdog ticks: undivided, divided, divider at the timer
    for (int i = 0; i < 3; i++) begin
      if (i == 0) begin
        wr(ADDR_OPTION, 8'h01);
        wr(ADDR_TIMER, 8'h00);
        wr(ADDR_OPTION, 8'h09);
      end
      // watchdog clear before each new setting
      wd_clr <= 1'b1;
      wait_clk(1);
      wd_clr <= 1'b0;
      wr(ADDR_OPTION, wo[i]);
      wait_clk(3);
      posts = 0;
      repeat (16) begin
        wd_tick <= 1'b1;
        wait_clk(1);
        wd_tick <= 1'b0;
        wait_clk(3);
      end
      wait_clk(10);
      chk("post ticks", we[i], posts);
    end
    $display("test watchdog done");
    complete_run();
  end

endmodule : tsp_timer8_tb

`default_nettype wire
